//--- common/status_pkg.sv
// constants, fault indices and state encoding for the status indicator encoder
// assumes a 50 MHz clock and slow pin-level inputs from the chair's monitors
// How it works
// - no fault, charge adequate: battery gauge lit steady, no flashing
// - low charge while working: battery gauge flashes slowly, driving still allowed
// - charging: gauge steps up; driving blocked until charger out and power cycled
// - system trip: all motion stopped, gauge flashes rapidly regardless of joystick
// - during a trip the fault class is the number of flashing bars
// - one bar: discharged battery or poor battery connection
// - two to five bars: left open, left short, right open, right short motor
// - six bars: external inhibit such as a connected charger stops driving
// - seven bars: joystick fault, including joystick off centre at power-on
// - eight control fault, nine brake open connection, ten supply overvoltage
// - cable communication fault and actuator trip each get their own distinct code
// - motor swap option exchanges left and right in the motor fault codes
// - speed mode: speed level n lights the n leftmost speed LEDs
// - profile mode: profile n lights only the nth LED from the left
// - locked system: speed/profile gauge ripples up and down
// - within one second of power-on the gauge settles steady or slow flashing
// - brakes release when joystick leaves rest, re-engage seconds after return
// - five speed levels, 1 lowest to 5 highest, shown on speed gauge
// - joystick held at power-on: ripple gauge, block motion, trip after five seconds
package status_pkg;

    localparam int N_BARS   = 10;
    localparam int N_LEDS   = 5;
    localparam int N_FAULTS = 12;
    localparam int MS_W     = 13;

    // clock rate and the millisecond tick derived from it
    localparam int CLK_NS     = 20;
    localparam int MS_NS      = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;

    // times in milliseconds unless the name says seconds
    localparam int SETTLE_S       = 1;
    localparam int JOY_TIMEOUT_S  = 5;
    localparam int STARTUP_MS_I   = 500;
    localparam int BRAKE_HOLD_MS_I = 1500;
    localparam logic [MS_W-1:0] SETTLE_MS      = MS_W'(SETTLE_S * 1000);
    localparam logic [MS_W-1:0] STARTUP_MS     = MS_W'(STARTUP_MS_I);
    localparam logic [MS_W-1:0] JOY_TIMEOUT_MS = MS_W'(JOY_TIMEOUT_S * 1000);
    localparam logic [MS_W-1:0] BRAKE_HOLD_MS  = MS_W'(BRAKE_HOLD_MS_I);
    localparam logic [MS_W-1:0] SLOW_HALF_MS   = 13'h1F4;
    localparam logic [MS_W-1:0] FAST_HALF_MS   = 13'h064;
    localparam logic [MS_W-1:0] STEP_MS        = 13'h0FA;
    localparam logic [MS_W-1:0] RIPPLE_MS      = 13'h050;

    // fault input bit positions; the reported bar count is index plus one
    localparam int FLT_BATT       = 0;
    localparam int FLT_LMOT_OPEN  = 1;
    localparam int FLT_LMOT_SHORT = 2;
    localparam int FLT_RMOT_OPEN  = 3;
    localparam int FLT_RMOT_SHORT = 4;
    localparam int FLT_INHIBIT    = 5;
    localparam int FLT_JOYSTICK   = 6;
    localparam int FLT_CONTROL    = 7;
    localparam int FLT_BRAKE      = 8;
    localparam int FLT_OVERVOLT   = 9;
    localparam int FLT_COMM       = 10;
    localparam int FLT_ACTUATOR   = 11;

    localparam logic [3:0] CODE_NONE     = 4'h0;
    localparam logic [3:0] CODE_JOYSTICK = 4'h7;
    localparam logic [3:0] CODE_COMM     = 4'hB;
    localparam logic [3:0] CODE_ACTUATOR = 4'hC;

    // antiphase bar masks for the two codes beyond ten bars
    localparam logic [N_BARS-1:0] MASK_ODD  = 10'h155;
    localparam logic [N_BARS-1:0] MASK_EVEN = 10'h2AA;
    localparam logic [N_BARS-1:0] MASK_LOW  = 10'h01F;
    localparam logic [N_BARS-1:0] MASK_HIGH = 10'h3E0;

    localparam logic [2:0] LEVEL_MIN = 3'h1;
    localparam logic [2:0] LEVEL_MAX = 3'h5;

    // gray coded along start, held, run, charge, trip
    typedef enum logic [2:0] {
        ST_START  = 3'h0,
        ST_HELD   = 3'h1,
        ST_RUN    = 3'h3,
        ST_CHARGE = 3'h2,
        ST_TRIP   = 3'h6
    } state_e;

endpackage

//--- design/status_indicator_encoder.sv
// status display and drive inhibit logic for the chair's control system
// assumes all inputs are slow pin levels; reset is the power cycle
`timescale 1ns/1ps
`default_nettype none
module status_indicator_encoder #(
    parameter int CYC_MS = status_pkg::CYC_PER_MS
) (
    input  wire logic                             clock,            // 50 MHz clock
    input  wire logic                             sys_rst,          // sync reset, power cycle
    input  wire logic                             joystick_off_rest, // joystick deflected
    input  wire logic                             charger_present,  // charger plugged in
    input  wire logic                             battery_low,      // charge is low
    input  wire logic [3:0]                       battery_bars,     // estimated bars 0..10
    input  wire logic [status_pkg::N_FAULTS-1:0]  fault_in,         // fault monitor levels
    input  wire logic                             motor_swap,       // exchange motor sides
    input  wire logic                             profile_mode,     // show profile not speed
    input  wire logic [2:0]                       speed_level,      // speed or profile 1..5
    input  wire logic                             system_locked,    // control system locked
    output logic      [status_pkg::N_BARS-1:0]    batt_gauge,       // battery bars, 1 lit
    output logic      [status_pkg::N_LEDS-1:0]    speed_gauge,      // speed LEDs, 1 lit
    output logic                                  drive_enable,     // motion permitted
    output logic      [1:0]                       brake_release,    // per brake, 1 released
    output logic      [3:0]                       trip_code         // latched trip code
);
    import status_pkg::*;

    typedef struct packed {
        logic                joy_m;
        logic                joy;
        logic                chg_m;
        logic                chg;
        logic                low_m;
        logic                low;
        logic                swap_m;
        logic                swap;
        logic                prof_m;
        logic                prof;
        logic                lock_m;
        logic                lock;
        logic [N_FAULTS-1:0] flt_m;
        logic [N_FAULTS-1:0] flt;
        logic [3:0]          bars_m;
        logic [3:0]          bars;
        logic [2:0]          lvl_m;
        logic [2:0]          lvl;
        state_e              st;
        logic [MS_W-1:0]     st_ms;
        logic [MS_W-1:0]     brk_ms;
        logic [MS_W-1:0]     slow_ms;
        logic [MS_W-1:0]     fast_ms;
        logic [MS_W-1:0]     step_ms;
        logic [MS_W-1:0]     rip_ms;
        logic                slow_ph;
        logic                fast_ph;
        logic [3:0]          step_pos;
        logic [3:0]          rip_pos;
        logic                rip_down;
        logic [3:0]          code;
        logic [N_BARS-1:0]   batt;
        logic [N_LEDS-1:0]   speed;
        logic                drive;
        logic                brake;
    } ctl_s;

    ctl_s s;
    ctl_s next_s;
    logic tick;
    logic [2:0] lvl_c;
    logic [N_LEDS-1:0] spd_pat;

    // millisecond enable; the count is a parameter so simulation can shorten it
    tick_divider #(
        .DIV (CYC_MS)
    ) u_ms_tick (
        .clock   (clock),
        .sys_rst (sys_rst),
        .tick    (tick)
    );

    // advance a ms timer; top bit reports the wrap
    function automatic logic [MS_W:0] adv(input logic [MS_W-1:0] c,
                                          input logic [MS_W-1:0] lim);
        if (c >= lim - MS_W'(1)) begin
            adv = {1'h1, {MS_W{1'h0}}};
        end else begin
            adv = {1'h0, c + MS_W'(1)};
        end
    endfunction

    // n leftmost bars lit
    function automatic logic [N_BARS-1:0] therm(input logic [3:0] n);
        therm = '0;
        for (int i = 0; i < N_BARS; i++) begin
            therm[i] = (4'(i) < n);
        end
    endfunction

    // motor fault meanings exchanged when the side swap option is on
    function automatic logic [N_FAULTS-1:0] swap_sides(input logic [N_FAULTS-1:0] f);
        swap_sides                 = f;
        swap_sides[FLT_LMOT_OPEN]  = f[FLT_RMOT_OPEN];
        swap_sides[FLT_RMOT_OPEN]  = f[FLT_LMOT_OPEN];
        swap_sides[FLT_LMOT_SHORT] = f[FLT_RMOT_SHORT];
        swap_sides[FLT_RMOT_SHORT] = f[FLT_LMOT_SHORT];
    endfunction

    // lowest active fault index wins; bar count is index plus one
    function automatic logic [3:0] fault_code(input logic [N_FAULTS-1:0] f);
        fault_code = CODE_NONE;
        for (int i = N_FAULTS - 1; i >= 0; i--) begin
            if (f[i]) begin
                fault_code = 4'(i + 1);
            end
        end
    endfunction

    // trip display: counted bars flash rapidly; comm code alternates odd and even bars, actuator code alternates low and high halves
    function automatic logic [N_BARS-1:0] trip_pat(input logic [3:0] c, input logic ph);
        case (c)
            CODE_COMM:     trip_pat = ph ? MASK_ODD : MASK_EVEN;
            CODE_ACTUATOR: trip_pat = ph ? MASK_LOW : MASK_HIGH;
            default:       trip_pat = ph ? therm(c) : '0;
        endcase
    endfunction

    // speed level clamped into the five documented steps
    assign lvl_c = (s.lvl < LEVEL_MIN) ? LEVEL_MIN :
                   (s.lvl > LEVEL_MAX) ? LEVEL_MAX : s.lvl;

    // one speed LED per generate slot
    for (genvar g = 0; g < N_LEDS; g++) begin : g_spd
        always_comb begin
            if (s.lock) begin
                spd_pat[g] = (3'(g) == s.rip_pos[3:1]);
            end else if (s.prof) begin
                spd_pat[g] = (3'(g) + 3'h1 == lvl_c);
            end else begin
                spd_pat[g] = (3'(g) < lvl_c);
            end
        end
    end

    always_comb begin
        logic [MS_W:0]        a;
        logic [N_FAULTS-1:0]  fv;
        logic [3:0]           fc;
        logic                 ripple_step;
        a           = '0;
        fv          = '0;
        fc          = CODE_NONE;
        ripple_step = 1'h0;
        next_s      = s;

        // two-stage synchronisers for every pin level
        next_s.joy_m  = joystick_off_rest;
        next_s.joy    = s.joy_m;
        next_s.chg_m  = charger_present;
        next_s.chg    = s.chg_m;
        next_s.low_m  = battery_low;
        next_s.low    = s.low_m;
        next_s.swap_m = motor_swap;
        next_s.swap   = s.swap_m;
        next_s.prof_m = profile_mode;
        next_s.prof   = s.prof_m;
        next_s.lock_m = system_locked;
        next_s.lock   = s.lock_m;
        next_s.flt_m  = fault_in;
        next_s.flt    = s.flt_m;
        next_s.bars_m = battery_bars;
        next_s.bars   = s.bars_m;
        next_s.lvl_m  = speed_level;
        next_s.lvl    = s.lvl_m;

        // animation timers; periods are package constants since no rates are fixed
        if (tick) begin
            a = adv(s.slow_ms, SLOW_HALF_MS);
            next_s.slow_ms = a[MS_W-1:0];
            next_s.slow_ph = s.slow_ph ^ a[MS_W];
            a = adv(s.fast_ms, FAST_HALF_MS);
            next_s.fast_ms = a[MS_W-1:0];
            next_s.fast_ph = s.fast_ph ^ a[MS_W];
            a = adv(s.step_ms, STEP_MS);
            next_s.step_ms = a[MS_W-1:0];
            if (a[MS_W]) begin
                next_s.step_pos = (s.step_pos >= 4'(N_BARS)) ? 4'h1 : s.step_pos + 4'h1;
            end
            a = adv(s.rip_ms, RIPPLE_MS);
            next_s.rip_ms = a[MS_W-1:0];
            ripple_step   = a[MS_W];
        end
        // bounce the ripple position between the end bars
        if (ripple_step) begin
            if (!s.rip_down) begin
                if (s.rip_pos >= 4'(N_BARS - 1)) begin
                    next_s.rip_down = 1'h1;
                    next_s.rip_pos  = s.rip_pos - 4'h1;
                end else begin
                    next_s.rip_pos = s.rip_pos + 4'h1;
                end
            end else begin
                if (s.rip_pos == 4'h0) begin
                    next_s.rip_down = 1'h0;
                    next_s.rip_pos  = 4'h1;
                end else begin
                    next_s.rip_pos = s.rip_pos - 4'h1;
                end
            end
        end

        fv = s.swap ? swap_sides(s.flt) : s.flt;
        fc = fault_code(fv);

        // state timer restarts on every state change below except the illegal-state fallback
        if (tick && s.st_ms != {MS_W{1'h1}}) begin
            next_s.st_ms = s.st_ms + MS_W'(1);
        end

        case (s.st)
            ST_START: begin
                if (fc != CODE_NONE) begin
                    next_s.st    = ST_TRIP;
                    next_s.code  = fc;
                    next_s.st_ms = '0;
                end else if (s.joy) begin
                    next_s.st    = ST_HELD;
                    next_s.st_ms = '0;
                end else if (tick && s.st_ms >= STARTUP_MS - MS_W'(1)) begin
                    // blink time is well inside the one second settle bound
                    next_s.st    = s.chg ? ST_CHARGE : ST_RUN;
                    next_s.st_ms = '0;
                end
            end
            ST_HELD: begin
                if (fc != CODE_NONE) begin
                    next_s.st    = ST_TRIP;
                    next_s.code  = fc;
                    next_s.st_ms = '0;
                end else if (tick && s.st_ms >= JOY_TIMEOUT_MS - MS_W'(1)) begin
                    next_s.st    = ST_TRIP;
                    next_s.code  = CODE_JOYSTICK;
                    next_s.st_ms = '0;
                end else if (!s.joy) begin
                    next_s.st    = s.chg ? ST_CHARGE : ST_RUN;
                    next_s.st_ms = '0;
                end
            end
            ST_RUN: begin
                if (fc != CODE_NONE) begin
                    next_s.st    = ST_TRIP;
                    next_s.code  = fc;
                    next_s.st_ms = '0;
                end else if (s.chg) begin
                    next_s.st       = ST_CHARGE;
                    next_s.step_pos = 4'h1;
                    next_s.st_ms    = '0;
                end
            end
            ST_CHARGE: begin
                // left only by a trip or a power cycle, even after unplugging
                if (fc != CODE_NONE) begin
                    next_s.st    = ST_TRIP;
                    next_s.code  = fc;
                    next_s.st_ms = '0;
                end
            end
            ST_TRIP: begin
                next_s.st = ST_TRIP;
            end
            default: begin
                next_s.st   = ST_TRIP;
                next_s.code = CODE_CONTROL_FALLBACK();
            end
        endcase

        // battery gauge per state, from the state being entered
        case (next_s.st)
            ST_START:  next_s.batt = '0;
            ST_HELD:   next_s.batt = therm(4'h1) << next_s.rip_pos;
            ST_RUN:    next_s.batt = (s.low && !s.slow_ph) ? '0 :
                                     therm(s.bars);
            ST_CHARGE: next_s.batt = therm(next_s.step_pos);
            ST_TRIP:   next_s.batt = trip_pat(next_s.code, s.fast_ph);
            default:   next_s.batt = '0;
        endcase

        next_s.speed = spd_pat;
        next_s.drive = (next_s.st == ST_RUN);

        // brakes follow the joystick only while driving is permitted
        if (next_s.st != ST_RUN) begin
            next_s.brake  = 1'h0;
            next_s.brk_ms = '0;
        end else if (s.joy) begin
            next_s.brake  = 1'h1;
            next_s.brk_ms = '0;
        end else if (s.brake && tick) begin
            a = adv(s.brk_ms, BRAKE_HOLD_MS);
            next_s.brk_ms = a[MS_W-1:0];
            if (a[MS_W]) begin
                next_s.brake = 1'h0;
            end
        end
    end

    // an illegal state code is treated as an internal control fault
    function automatic logic [3:0] CODE_CONTROL_FALLBACK();
        CODE_CONTROL_FALLBACK = 4'(FLT_CONTROL + 1);
    endfunction

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign batt_gauge    = s.batt;
    assign speed_gauge   = s.speed;
    assign drive_enable  = s.drive;
    assign brake_release = {2{s.brake}};
    assign trip_code     = s.code;
endmodule
`default_nettype wire

//--- design/tick_divider.sv
// divider giving a one-cycle enable pulse every DIV clocks
// assumes a single clock domain and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int DIV = 50000
) (
    input  wire logic clock,   // system clock
    input  wire logic sys_rst, // synchronous reset, high
    output logic      tick     // one-cycle enable pulse
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } div_s;

    div_s s;
    div_s next_s;

    // count up one period, then fire a single pulse
    always_comb begin
        next_s      = s;
        next_s.tick = 1'h0;
        if (s.cnt == W'(DIV - 1)) begin
            next_s.cnt  = '0;
            next_s.tick = 1'h1;
        end else begin
            next_s.cnt = s.cnt + W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

//--- verification/gauge_reader.sv
// user model: reads the battery gauge the way a person counts bars
// assumes clr is driven off the falling edge and held across one rising edge
`timescale 1ns/1ps
`default_nettype none
module gauge_reader (
    input  wire logic                          clock, // system clock
    input  wire logic                          clr,   // restart the reading
    input  wire logic [status_pkg::N_BARS-1:0] gauge, // battery bars shown
    output logic      [status_pkg::N_BARS-1:0] seen,  // bars lit since clr
    output var int                             flips  // pattern changes since clr
);
    logic [status_pkg::N_BARS-1:0] last;
    // flashing bars are counted by what ever lit, not by one snapshot
    always_ff @(posedge clock) begin
        last <= gauge;
        if (clr) begin
            seen  <= 10'h000;
            flips <= 0;
        end else begin
            seen <= seen | gauge;
            if (gauge !== last) flips <= flips + 1;
        end
    end
endmodule
`default_nettype wire

//--- verification/status_indicator_encoder_chk.sv
// pin checker for the status encoder
// assumes a bind onto the encoder, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module status_indicator_encoder_chk #(
    parameter int CYC_MS = 4
) (
    input wire logic                            clock,             // clock
    input wire logic                            sys_rst,           // reset
    input wire logic                            joystick_off_rest, // deflected
    input wire logic                            charger_present,   // charger in
    input wire logic [status_pkg::N_FAULTS-1:0] fault_in,          // faults
    input wire logic                            profile_mode,      // profile view
    input wire logic [2:0]                      speed_level,       // level
    input wire logic                            system_locked,     // locked
    input wire logic [status_pkg::N_BARS-1:0]   batt_gauge,        // bars
    input wire logic [status_pkg::N_LEDS-1:0]   speed_gauge,       // speed leds
    input wire logic                            drive_enable,      // drive
    input wire logic [1:0]                      brake_release,     // brakes
    input wire logic [3:0]                      trip_code          // code
);
    import status_pkg::*;
    localparam int BRK_LIM = (BRAKE_HOLD_MS_I + 2) * CYC_MS + 8;
    int         rest_cnt;
    logic [4:0] exp_spd;
    // time at rest; saturates so a long idle never wraps it
    always_ff @(posedge clock) begin
        if (sys_rst || joystick_off_rest) rest_cnt <= 0;
        else if (rest_cnt < BRK_LIM) rest_cnt <= rest_cnt + 1;
    end
    // speed gauge due for the pins as they stand
    assign exp_spd = profile_mode ? 5'(6'h01 << (speed_level - 3'h1))
                                  : 5'((6'h01 << speed_level) - 6'h01);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
        !drive_enable && trip_code == 4'h0 && batt_gauge == 10'h000) else $error("reset missed");
    trip_stop_a: assert property (trip_code != 4'h0 |->
        !drive_enable && brake_release == 2'b00) else $error("motion in trip");
    trip_latch_a: assert property (trip_code != 4'h0 |=>
        $stable(trip_code)) else $error("trip code moved");
    trip_bars_a: assert property (trip_code inside {[4'h1:4'hA]} |=>
        (batt_gauge >> trip_code) == 10'h000) else $error("bar above count lit");
    fault_trip_a: assert property (drive_enable && fault_in != 12'h000 |->
        ##[1:4] trip_code != 4'h0) else $error("fault not tripped");
    brake_on_a: assert property ((drive_enable && joystick_off_rest) [*5] |->
        brake_release == 2'b11) else $error("brakes not released");
    brake_off_a: assert property (rest_cnt == BRK_LIM |->
        brake_release == 2'b00) else $error("brakes not re-engaged");
    speed_show_a: assert property ((!system_locked &&
        speed_level inside {[3'h1:3'h5]} && $stable({profile_mode, speed_level})) [*6]
        |-> speed_gauge == exp_spd) else $error("speed gauge wrong");
    lock_ripple_a: assert property (system_locked [*6] |->
        $onehot(speed_gauge)) else $error("lock pattern not one led");
    charge_stop_a: assert property (charger_present [*5] |->
        !drive_enable) else $error("driving while charging");
    // main scenarios reached
    cover property (trip_code == 4'hC);
    cover property (charger_present [*5] ##1 !charger_present);
    cover property (system_locked [*6]);
endmodule
`default_nettype wire

//--- verification/status_indicator_encoder_tb.sv
// self-checking bench for the status encoder
// assumes the gauge reader and the bound checker compile alongside
`timescale 1ns/1ps
`default_nettype none
module status_indicator_encoder_tb;
    import status_pkg::*;
    localparam int CM = 2; // cycles per ms, keeps long counts short
    logic                clock = 1'b0, sys_rst = 1'b1, charger_present = 1'b0;
    logic                joystick_off_rest = 1'b0, battery_low = 1'b0, motor_swap = 1'b0;
    logic                profile_mode = 1'b0, system_locked = 1'b0, rd_clr = 1'b1;
    logic [2:0]          speed_level = 3'h1;
    logic [3:0]          battery_bars = 4'h6;
    logic [N_FAULTS-1:0] fault_in = 12'h000;
    logic [N_BARS-1:0]   batt_gauge, rd_seen;
    logic [N_LEDS-1:0]   speed_gauge;
    logic [3:0]          trip_code;
    logic [1:0]          brake_release;
    logic                drive_enable;
    int                  rd_flips, n_mismatch = 0, tests_run = 0;
    // 50 MHz clock
    always #10 clock = ~clock;
    status_indicator_encoder #(.CYC_MS(CM)) i_dut (.clock, .sys_rst, .joystick_off_rest,
        .charger_present, .battery_low, .battery_bars, .fault_in, .motor_swap, .profile_mode,
        .speed_level, .system_locked, .batt_gauge, .speed_gauge, .drive_enable,
        .brake_release, .trip_code);
    gauge_reader i_rd (.clock, .clr(rd_clr), .gauge(batt_gauge), .seen(rd_seen), .flips(rd_flips));
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wait_ms(input int n);
        repeat (n * CM) @(negedge clock);
    endtask
    // power cycle: eight cycles of reset, then past the start-up blink
    task automatic boot();
        sys_rst = 1'b1;
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        wait_ms(600);
    endtask
    // let the user model read the gauge for n ms
    task automatic watch(input int n);
        rd_clr = 1'b1;
        @(negedge clock);
        rd_clr = 1'b0;
        wait_ms(n);
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // steady gauge, slow flash when low, brakes follow the joystick
    task automatic t_gauge();
        boot();
        watch(400);
        cmp(16'h003F, 16'(rd_seen));
        cmp(16'h0000, 16'(rd_flips));
        battery_low = 1'b1;
        joystick_off_rest = 1'b1;
        watch(1200);
        cmp(16'h0001, 16'(rd_flips inside {[2:3]}));
        cmp(16'h0007, 16'({drive_enable, brake_release}));
        battery_low = 1'b0;
        joystick_off_rest = 1'b0;
        wait_ms(1000);
        cmp(16'h0003, 16'(brake_release));
        wait_ms(1000);
        cmp(16'h0000, 16'(brake_release));
    endtask
    // each level and profile on the speed gauge, then the lock ripple
    task automatic t_speed();
        logic [15:0] e;
        for (int m = 0; m < 2; m++) begin
            for (int l = 1; l < 6; l++) begin
                profile_mode = m[0];
                speed_level  = 3'(l);
                repeat (6) @(negedge clock);
                e = m ? 16'h0001 << (l - 1) : (16'h0001 << l) - 16'h0001;
                cmp(e, 16'(speed_gauge));
            end
        end
        system_locked = 1'b1;
        wait_ms(10);
        repeat (3) begin
            e = 16'(speed_gauge);
            wait_ms(250);
            cmp(16'h0001, 16'($onehot(speed_gauge) && 16'(speed_gauge) != e));
        end
        system_locked = 1'b0;
    endtask
    // one fault class after a fresh power-on; swap exchanges motor sides
    task automatic t_trip(input int i, input logic sw);
        int c;
        c = (sw && i > 0 && i < 5) ? (i < 3 ? i + 3 : i - 1) : i + 1;
        motor_swap = sw;
        boot();
        fault_in[i] = 1'b1;
        wait_ms(5);
        watch(400);
        cmp(16'(c), 16'(trip_code));
        cmp(16'h0000, 16'({drive_enable, brake_release}));
        cmp(c > 10 ? 16'h03FF : (16'h0001 << c) - 16'h0001, 16'(rd_seen));
        cmp(16'h0001, 16'(rd_flips >= 3));
        fault_in = 12'h000;
        wait_ms(5);
        cmp(16'(c), 16'(trip_code));
    endtask
    // charging steps the gauge, blocks driving for good, yields to a trip
    task automatic t_charge();
        boot();
        charger_present = 1'b1;
        watch(2700);
        cmp(16'h03FF, 16'(rd_seen));
        cmp(16'h0001, 16'(rd_flips >= 10));
        charger_present = 1'b0;
        wait_ms(300);
        cmp(16'h0000, 16'(drive_enable));
        fault_in = 12'h200;
        wait_ms(50);
        cmp(16'h000A, 16'(trip_code));
        fault_in = 12'h000;
    endtask
    // joystick held through power-on: motion blocked, ripple, then trip
    task automatic t_held();
        joystick_off_rest = 1'b1;
        boot();
        watch(300);
        cmp(16'h0000, 16'(drive_enable));
        cmp(16'h0001, 16'(rd_flips >= 2));
        wait_ms(4700);
        joystick_off_rest = 1'b0;
        wait_ms(50);
        cmp(16'h0007, 16'(trip_code));
    endtask
    // scenarios in order, then the verdict
    initial begin
        t_gauge();
        t_speed();
        for (int i = 0; i < 12; i++) t_trip(i, 1'b0);
        for (int i = 1; i < 5; i++) t_trip(i, 1'b1);
        motor_swap = 1'b0;
        t_charge();
        t_held();
        final_report();
    end
    // cut a hang short; the run needs about 1.2 ms
    initial begin
        #3000000;
        n_mismatch++;
        final_report();
    end
endmodule
bind status_indicator_encoder status_indicator_encoder_chk #(.CYC_MS(CYC_MS)) i_chk (
    .clock, .sys_rst, .joystick_off_rest, .charger_present, .fault_in, .profile_mode,
    .speed_level, .system_locked, .batt_gauge, .speed_gauge, .drive_enable, .brake_release,
    .trip_code);
`default_nettype wire
